/* File: hdl/crfc_consts.vh */
/*
 constants of the clock ratio frequency counter: register addresses,
 field positions, reset values, state codes and delay counts.
 assumes it is included by bare name from the design files.
*/
`ifndef CRFC_CONSTS_VH
`define CRFC_CONSTS_VH

`define CRFC_ADDR_CTRL 8'h9b
`define CRFC_ADDR_IVL 8'h9d
`define CRFC_ADDR_CNT0 16'h4008
`define CRFC_ADDR_CNT1 16'h4009
`define CRFC_ADDR_CNT2 16'h400a
`define CRFC_ADDR_CNT3 16'h400b

`define CRFC_BIT_DONE 7
`define CRFC_BIT_BUSY 6
`define CRFC_BIT_SEL 5
`define CRFC_MODE_HI 2
`define CRFC_MODE_LO 0
`define CRFC_IVL_HI 5

`define CRFC_RST_CTRL 8'h00
`define CRFC_RST_IVL 6'h00
`define CRFC_RST_CNT 23'h000000

`define CRFC_MODE_OFF 3'h0
`define CRFC_MODE_GPIO 3'h1
`define CRFC_MODE_OSC 3'h2
`define CRFC_MODE_SYS 3'h3
`define CRFC_MODE_XO 3'h4
`define CRFC_MODE_SLEEP 3'h6

`define CRFC_IVL_MAX 6'h2b
`define CRFC_CNT_W 23

`define CRFC_ST_IDLE 3'h0
`define CRFC_ST_SYNC 3'h1
`define CRFC_ST_WAIT 3'h2
`define CRFC_ST_RUN 3'h3
`define CRFC_ST_FIN 3'h4

`define CRFC_SYNC_DLY 2'h2
`define CRFC_DONE_DLY 2'h3

`endif

/* File: hdl/crfc_sync.v */
/*
 two-flop synchroniser with rising-edge pulse for a vector of pins.
 assumes the inputs are asynchronous to clk and reset is already synchronous
 in release.
*/
`timescale 1ns/1ps
module crfc_sync #(
    parameter W = 7
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] din,
    output wire [W-1:0] rise
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_r;
            reg sync_r;
            reg last_r;
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                    last_r <= 1'b0;
                end else begin
                    meta_r <= din[i];
                    sync_r <= meta_r;
                    last_r <= sync_r;
                end
            end
            // edge taken after the second flop only
            assign rise[i] = sync_r & ~last_r;
        end
    endgenerate
endmodule // crfc_sync

/* File: hdl/crfc_top.v */
/*
 clock ratio frequency counter: an interval window timed by a selectable
 slow clock gates a 23-bit counter of a selectable fast clock.
 assumes an sfr byte port and an xreg byte read port from the
 microcontroller, and that every source clock is slower than half of CLOCK.
*/
// Summary of operation
// - done flag is level request, held until cleared
// - done accepts writes; writing one raises request
// - busy falling at window end sets the done flag
// - busy write one with nonzero mode restarts, clears done, discards
// - select bit picks lc or divider source
// - mode zero holds both counted sources inactive
// - control bits four to three read zero
// - mode field selects interval clock source
// - window is (2+f0) times 2 to f[5:1]
// - field above 43 gives one-cycle window
// - count read as four big-endian bytes
// - count bits above 22 read zero
// - reading while counting returns live value
// - sync delay, first edge starts, last stops
// - busy clears first, done follows few cycles later
// - count held until disabled or retriggered
// - nonzero mode idles; mode zero stops immediately
`timescale 1ns/1ps
`include "crfc_consts.vh"
module crfc_top (
    input wire CLOCK,
    input wire RESET_N,
    input wire [7:0] SFR_ADDR,
    input wire SFR_WE,
    input wire [7:0] SFR_WDATA,
    output wire [7:0] SFR_RDATA,
    input wire [15:0] XREG_ADDR,
    output wire [7:0] XREG_RDATA,
    input wire IVL_CLK_GPIO,
    input wire IVL_CLK_OSC,
    input wire IVL_CLK_SYS,
    input wire IVL_CRYSTAL_CLOCK,
    input wire IVL_CLK_SLEEP,
    input wire CNT_CLK_LC,
    input wire CNT_CLK_DIV,
    output wire LC_SRC_EN,
    output wire DIV_SRC_EN,
    output wire DONE_IRQ
);
    reg rst_meta_r;
    reg rst_n_r;
    reg done_r;
    reg busy_r;
    reg sel_r;
    reg [2:0] mode_r;
    reg [5:0] ivl_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [1:0] dly_r;
    reg [1:0] dly_nxt;
    reg [23:0] left_r;
    reg [23:0] left_nxt;
    reg [22:0] cnt_r;
    reg [22:0] cnt_nxt;
    reg busy_nxt;
    reg done_nxt;
    reg [7:0] sfr_rd_r;
    reg [7:0] xreg_rd_r;
    reg lc_en_r;
    reg div_en_r;
    reg ivl_rise;
    wire [6:0] rise;
    wire cnt_rise;
    wire ctrl_wr;
    wire trig;
    wire [23:0] n_cycles;
    wire [31:0] cnt_word;

    // reset taken asynchronously, released through two flops
    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // foreign clocks are sampled, so sources must stay below CLOCK/2
    crfc_sync #(
        .W(7)
    ) u_sync (
        .clk(CLOCK),
        .rst_n(rst_n_r),
        .din({CNT_CLK_DIV, CNT_CLK_LC, IVL_CLK_SLEEP, IVL_CRYSTAL_CLOCK,
              IVL_CLK_SYS, IVL_CLK_OSC, IVL_CLK_GPIO}),
        .rise(rise)
    );

    always @* begin
        case (mode_r)
            `CRFC_MODE_GPIO: ivl_rise = rise[0];
            `CRFC_MODE_OSC: ivl_rise = rise[1];
            `CRFC_MODE_SYS: ivl_rise = rise[2];
            `CRFC_MODE_XO: ivl_rise = rise[3];
            `CRFC_MODE_SLEEP: ivl_rise = rise[4];
            default: ivl_rise = 1'b0;
        endcase
    end

    assign cnt_rise = sel_r ? rise[6] : rise[5];

    assign n_cycles = (ivl_r > `CRFC_IVL_MAX) ? 24'h000001 :
        (({22'h000000, 1'b1, ivl_r[0]}) << ivl_r[5:1]);

    assign ctrl_wr = SFR_WE && (SFR_ADDR == `CRFC_ADDR_CTRL);
    // a trigger is only meaningful with a functional mode written alongside
    assign trig = ctrl_wr && SFR_WDATA[`CRFC_BIT_BUSY] &&
        (SFR_WDATA[`CRFC_MODE_HI:`CRFC_MODE_LO] != `CRFC_MODE_OFF);

    always @* begin
        state_nxt = state_r;
        dly_nxt = dly_r;
        left_nxt = left_r;
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        done_nxt = done_r;
        case (state_r)
            `CRFC_ST_SYNC: begin
                if (dly_r == `CRFC_SYNC_DLY) begin
                    state_nxt = `CRFC_ST_WAIT;
                end else begin
                    dly_nxt = dly_r + 2'h1;
                end
            end
            `CRFC_ST_WAIT: begin
                if (ivl_rise) begin
                    state_nxt = `CRFC_ST_RUN;
                    left_nxt = n_cycles;
                end
            end
            `CRFC_ST_RUN: begin
                if (cnt_rise) begin
                    cnt_nxt = cnt_r + 23'h000001;
                end
                if (ivl_rise) begin
                    left_nxt = left_r - 24'h000001;
                    if (left_r == 24'h000001) begin
                        state_nxt = `CRFC_ST_FIN;
                        busy_nxt = 1'b0;
                        dly_nxt = 2'h0;
                    end
                end
            end
            `CRFC_ST_FIN: begin
                if (dly_r == `CRFC_DONE_DLY) begin
                    state_nxt = `CRFC_ST_IDLE;
                end else begin
                    dly_nxt = dly_r + 2'h1;
                end
            end
            default: begin
                state_nxt = `CRFC_ST_IDLE;
            end
        endcase
        // software write of the flag, done bit takes any value
        if (ctrl_wr) begin
            done_nxt = SFR_WDATA[`CRFC_BIT_DONE];
        end
        if (trig) begin
            state_nxt = `CRFC_ST_SYNC;
            dly_nxt = 2'h0;
            cnt_nxt = `CRFC_RST_CNT;
            busy_nxt = 1'b1;
            done_nxt = 1'b0;
        end
        // hardware set wins over a same-cycle software clear
        if (state_r == `CRFC_ST_FIN && dly_r == `CRFC_DONE_DLY && !trig) begin
            done_nxt = 1'b1;
        end
        if (ctrl_wr && SFR_WDATA[`CRFC_MODE_HI:`CRFC_MODE_LO] == `CRFC_MODE_OFF) begin
            state_nxt = `CRFC_ST_IDLE;
            busy_nxt = 1'b0;
            cnt_nxt = `CRFC_RST_CNT;
        end
    end

    always @(posedge CLOCK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= `CRFC_ST_IDLE;
            dly_r <= 2'h0;
            left_r <= 24'h000000;
            cnt_r <= `CRFC_RST_CNT;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            sel_r <= 1'b0;
            mode_r <= `CRFC_MODE_OFF;
            ivl_r <= `CRFC_RST_IVL;
            lc_en_r <= 1'b0;
            div_en_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            dly_r <= dly_nxt;
            left_r <= left_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            if (ctrl_wr) begin
                sel_r <= SFR_WDATA[`CRFC_BIT_SEL];
                mode_r <= SFR_WDATA[`CRFC_MODE_HI:`CRFC_MODE_LO];
            end
            if (SFR_WE && SFR_ADDR == `CRFC_ADDR_IVL) begin
                ivl_r <= SFR_WDATA[`CRFC_IVL_HI:0];
            end
            lc_en_r <= (mode_r != `CRFC_MODE_OFF) && !sel_r;
            div_en_r <= (mode_r != `CRFC_MODE_OFF) && sel_r;
        end
    end

    assign cnt_word = {9'h000, cnt_r};

    // read data lags the address by one clock
    always @(posedge CLOCK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sfr_rd_r <= 8'h00;
            xreg_rd_r <= 8'h00;
        end else begin
            case (SFR_ADDR)
                `CRFC_ADDR_CTRL: sfr_rd_r <= {done_r, busy_r, sel_r, 2'b00, mode_r};
                `CRFC_ADDR_IVL: sfr_rd_r <= {2'b00, ivl_r};
                default: sfr_rd_r <= 8'h00;
            endcase
            case (XREG_ADDR)
                `CRFC_ADDR_CNT0: xreg_rd_r <= cnt_word[31:24];
                `CRFC_ADDR_CNT1: xreg_rd_r <= cnt_word[23:16];
                `CRFC_ADDR_CNT2: xreg_rd_r <= cnt_word[15:8];
                `CRFC_ADDR_CNT3: xreg_rd_r <= cnt_word[7:0];
                default: xreg_rd_r <= 8'h00;
            endcase
        end
    end

    assign SFR_RDATA = sfr_rd_r;
    assign XREG_RDATA = xreg_rd_r;
    assign LC_SRC_EN = lc_en_r;
    assign DIV_SRC_EN = div_en_r;
    assign DONE_IRQ = done_r;
endmodule // crfc_top

/* File: sim/crfc_asserts.sv */
/* port checker for crfc_top, bound at the foot of this file.
 assumes control writes come at least two cycles apart. */
`timescale 1ns/1ps
module crfc_asserts (
    input wire CLOCK,
    input wire RESET_N,
    input wire [7:0] SFR_ADDR,
    input wire SFR_WE,
    input wire [7:0] SFR_WDATA,
    input wire [7:0] SFR_RDATA,
    input wire [15:0] XREG_ADDR,
    input wire [7:0] XREG_RDATA,
    input wire LC_SRC_EN,
    input wire DIV_SRC_EN,
    input wire DONE_IRQ
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);
    wire cw = SFR_WE && SFR_ADDR == 8'h9b;
    wire nz = SFR_WDATA[2:0] != 3'h0;
    property p_off;
        cw && !nz |-> ##2 !LC_SRC_EN && !DIV_SRC_EN;
    endproperty
    a_off: assert property (p_off) else $error("source on while off");
    property p_sel;
        cw && nz |-> ##2 LC_SRC_EN != DIV_SRC_EN && DIV_SRC_EN == $past(SFR_WDATA[5], 2);
    endproperty
    a_sel: assert property (p_sel) else $error("wrong counted source");
    property p_rsv;
        SFR_ADDR == 8'h9b |=> SFR_RDATA[4:3] == 2'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_top;
        XREG_ADDR == 16'h4008 ##1 XREG_ADDR == 16'h4009 |-> XREG_RDATA == 8'h00 ##1 !XREG_RDATA[7];
    endproperty
    a_top: assert property (p_top) else $error("upper count bits set");
    // a write may load the flag, so the edge after one is excused
    property p_hold;
        DONE_IRQ && !cw && !$past(cw) |=> DONE_IRQ;
    endproperty
    a_hold: assert property (p_hold) else $error("done dropped");
    property p_set;
        cw && SFR_WDATA[7:6] == 2'h2 |-> ##[1:2] DONE_IRQ;
    endproperty
    a_set: assert property (p_set) else $error("done not raised");
    property p_trig;
        cw && nz && SFR_WDATA[6] |-> ##2 !DONE_IRQ;
    endproperty
    a_trig: assert property (p_trig) else $error("done not cleared");
    property p_fin;
        $past(SFR_ADDR, 2) == 8'h9b && !$past(SFR_WE) && !$past(SFR_WE, 2) && !$past(SFR_WE, 3)
            && $fell(SFR_RDATA[6]) |-> ##[1:6] DONE_IRQ;
    endproperty
    a_fin: assert property (p_fin) else $error("done late after busy");
endmodule // crfc_asserts
bind crfc_top crfc_asserts u_crfc_asserts (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .SFR_ADDR(SFR_ADDR), .SFR_WE(SFR_WE), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
    .XREG_ADDR(XREG_ADDR), .XREG_RDATA(XREG_RDATA), .LC_SRC_EN(LC_SRC_EN),
    .DIV_SRC_EN(DIV_SRC_EN), .DONE_IRQ(DONE_IRQ));

/* File: sim/tb_top.sv */
/* bench for crfc_top: register accesses and timed count runs.
 assumes every source clock stays below half of CLOCK. */
`timescale 1ns/1ps
module tb_top;
    reg CLOCK, RESET_N, SFR_WE, ivl, lc, dv;
    reg [7:0] SFR_ADDR, SFR_WDATA, d;
    reg [15:0] XREG_ADDR;
    reg [4:0] on;
    reg [31:0] w;
    wire [7:0] SFR_RDATA, XREG_RDATA;
    wire LC_SRC_EN, DIV_SRC_EN, DONE_IRQ;
    wire [4:0] ic = {5{ivl}} & on;
    integer num_errors, num_checks, i, j, k;
    crfc_top u_crfc_top (.CLOCK(CLOCK), .RESET_N(RESET_N), .SFR_ADDR(SFR_ADDR),
        .SFR_WE(SFR_WE), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .XREG_ADDR(XREG_ADDR),
        .XREG_RDATA(XREG_RDATA), .IVL_CLK_GPIO(ic[0]), .IVL_CLK_OSC(ic[1]),
        .IVL_CLK_SYS(ic[2]), .IVL_CRYSTAL_CLOCK(ic[3]), .IVL_CLK_SLEEP(ic[4]), .CNT_CLK_LC(lc),
        .CNT_CLK_DIV(dv), .LC_SRC_EN(LC_SRC_EN), .DIV_SRC_EN(DIV_SRC_EN), .DONE_IRQ(DONE_IRQ));
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    // no counted edge shares a cycle with a window edge, so counts are exact
    always #100 ivl = ~ivl;
    // counted clocks start 1 ns late, so they never move on a sampling edge
    initial begin
        #1;
        forever #25 lc = ~lc;
    end
    initial begin
        #1;
        forever #12.5 dv = ~dv;
    end
    task cmp(input [31:0] g, input [31:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("mismatch at %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d errors %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge CLOCK) #1;
    endtask
    task wr(input [7:0] a, input [7:0] v);
        begin
            @(posedge CLOCK) #1 SFR_ADDR = a;
            SFR_WDATA = v;
            SFR_WE = 1'b1;
            @(posedge CLOCK) #1 SFR_WE = 1'b0;
        end
    endtask
    task rs(input [7:0] a);
        begin
            @(posedge CLOCK) #1 SFR_ADDR = a;
            @(posedge CLOCK) #1 d = SFR_RDATA;
        end
    endtask
    // bytes are live, so a read while busy may tear
    task rc;
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge CLOCK) #1 XREG_ADDR = 16'h4008 + i[15:0];
            @(posedge CLOCK) #1 w = {w[23:0], XREG_RDATA};
        end
    endtask
    task run(input [2:0] m, input s, input [5:0] f);
        begin
            on = m == 3'h6 ? 5'h10 : 5'h01 << (m - 3'h1);
            wr(8'h9d, {2'h0, f});
            wr(8'h9b, {2'h1, s, 2'h0, m});
            rs(8'h9b);
            cmp(d[7:6], 2'h1);
            cmp({LC_SRC_EN, DIV_SRC_EN}, {~s, s});
            for (j = 0; d[6] !== 1'b0 && j < 2000; j = j + 1)
                rs(8'h9b);
            // a stuck busy bit is counted here and the run goes on to the report
            cmp(j < 2000, 1'b1);
            cyc(6);
            cmp(DONE_IRQ, 1'b1);
            rc;
            cmp(w, (f > 6'd43 ? 32'h1 : (32'h2 + f[0]) << f[5:1]) * (s ? 32'h8 : 32'h4));
        end
    endtask
    initial begin
        num_errors = 0;
        num_checks = 0;
        {RESET_N, SFR_WE, SFR_ADDR, SFR_WDATA, XREG_ADDR, on, w, ivl, lc, dv} = 0;
        cyc(16);
        RESET_N = 1'b1;
        cyc(3);
        rs(8'h9b);
        cmp(d, 8'h00);
        rs(8'h80);
        cmp(d, 8'h00);
        rc;
        cmp(w, 32'h0);
        wr(8'h9d, 8'hff);
        rs(8'h9d);
        cmp(d, 8'h3f);
        wr(8'h9b, 8'h18);
        rs(8'h9b);
        cmp(d, 8'h00);
        $display("test registers done");
        wr(8'h9b, 8'h80);
        rs(8'h9b);
        cmp({d, DONE_IRQ}, 9'h101);
        wr(8'h9b, 8'h00);
        rs(8'h9b);
        cmp({d, DONE_IRQ}, 9'h000);
        $display("test software done flag done");
        for (k = 1; k < 7; k = k + 1)
            if (k != 5)
                run(k[2:0], 1'b0, 6'd1);
        $display("test interval sources done");
        run(3'h3, 1'b0, 6'd0);
        run(3'h3, 1'b0, 6'd44);
        run(3'h3, 1'b0, 6'd63);
        run(3'h3, 1'b1, 6'd2);
        $display("test windows and select done");
        wr(8'h9b, 8'h43);
        cyc(60);
        rc;
        cmp(w != 32'h0, 1'b1);
        run(3'h3, 1'b0, 6'd3);
        $display("test restart done");
        wr(8'h9b, 8'h43);
        cyc(60);
        wr(8'h9b, 8'h00);
        rs(8'h9b);
        cmp(d, 8'h00);
        rc;
        cyc(8);
        cmp(w, 32'h0);
        cmp({DONE_IRQ, LC_SRC_EN, DIV_SRC_EN}, 3'h0);
        $display("test disable done");
        tally_and_finish;
    end
endmodule // tb_top
